/* File: design/tecc_cfg.svh */
`ifndef TECC_CFG_SVH
`define TECC_CFG_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define TECC_OFF_CTR1_CTRL 8'h00
`define TECC_OFF_CTR1_PRELOAD 8'h04
`define TECC_OFF_CTR1_COUNT 8'h08
`define TECC_OFF_CTR2_CTRL 8'h0C
`define TECC_OFF_CTR2_PRELOAD 8'h10
`define TECC_OFF_CTR2_COUNT 8'h14
`define TECC_OFF_IRQ_STATUS 8'h18
`define TECC_OFF_IRQ_MASK 8'h1C
// ****************************************************************
// reset values and masks
// ****************************************************************
`define TECC_CTR1_CTRL_RST 8'h08
`define TECC_CTR2_CTRL_RST 8'h00
`define TECC_CTR2_CTRL_WMASK 8'hD7
`define TECC_CNT_FULL 8'hFF
`define TECC_PSC_RST 7'h00
// ****************************************************************
// axi responses and counter indices
// ****************************************************************
`define TECC_RESP_OKAY 2'b00
`define TECC_RESP_SLVERR 2'b10
`define TECC_CTR1 0
`define TECC_CTR2 1
`define TECC_NUM_CTR 2
`endif

/* File: design/tecc_pkg.sv */
package tecc_pkg;
  // counter operating mode codes
  typedef enum logic [1:0]
  {
    TECC_MODE_PPG = 2'b00,
    TECC_MODE_EVENT = 2'b01,
    TECC_MODE_TIMER = 2'b10,
    TECC_MODE_PULSE = 2'b11
  } tecc_mode_t;

  // control register layout, shared by both counters
  typedef struct packed
  {
    logic [1:0] mode;
    logic spare;
    logic run;
    logic edge_sel;
    logic [2:0] divide;
  } tecc_ctrl_t;

  // whole module state
  typedef struct packed
  {
    tecc_ctrl_t ctr1_ctrl;
    tecc_ctrl_t ctr2_ctrl;
    logic [1:0][7:0] preload;
    logic [1:0][7:0] count;
    logic [6:0] psc;
    logic ev_s1;
    logic ev_s2;
    logic ev_d;
    logic pulse_active;
    logic [1:0] sts;
    logic [1:0] msk;
    logic irq;
    logic [1:0] ovf_pulse;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tecc_state_t;
endpackage

/* File: design/tecc_timer_event_counter_ctrl.sv */
// Functional notes
// R1: event mode counts rising/falling per edge bit
// R2: pulse mode edge 0: falling starts, rising stops
// R3: internal clock is prescaler clock over 2^divide
// R4: counter two mode 00 PPG, 10 timer
// R5: counter two modes 01 and 11 idle
// R6: counter two control bits 5, 3 read zero
// R7: counter two run bit stops or allows counting
// R8: PPG mode ignores writes to run bit
// R9: timer mode increments per internal clock fall
// R10: overflow raises interrupt, reloads preload, continues
// R11: stopped counter holds value, no overflow
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "tecc_cfg.svh"

module tecc_timer_event_counter_ctrl
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ctr1_event_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic irq_o,
  output logic ctr1_overflow_o,
  output logic ctr2_overflow_o,
  output tecc_pkg::tecc_mode_t ctr2_operating_mode_o
);
  import tecc_pkg::*;

  tecc_state_t st_reg;
  tecc_state_t st_next;
  logic [`TECC_NUM_CTR-1:0] tick;
  logic [`TECC_NUM_CTR-1:0][2:0] div_sel;

  // ****************************************************************
  // prescaler taps
  // ****************************************************************
  assign div_sel[`TECC_CTR1] = st_reg.ctr1_ctrl.divide;
  assign div_sel[`TECC_CTR2] = st_reg.ctr2_ctrl.divide;

  // one enable pulse per fall of each counter's internal clock;
  // the low divide bits all at one means the tap falls next edge
  genvar gi;
  generate
    for (gi = 0; gi < `TECC_NUM_CTR; gi++)
    begin : g_tick
      logic [7:0] span;
      logic [6:0] low_mask;
      assign span = 8'(8'h01 << div_sel[gi]);
      assign low_mask = 7'(span - 8'h01);
      assign tick[gi] = &(st_reg.psc | ~low_mask); // R3 R9
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  // reads and writes, counting and overflow in one pass
  always_comb
  begin
    logic rise;
    logic fall;
    logic start_edge;
    logic stop_edge;
    logic [1:0] adv;
    logic [1:0] ovf;
    logic do_write;
    logic wr_ok;
    logic [7:0] rd_val;
    logic rd_ok;
    rise = 1'b0;
    fall = 1'b0;
    start_edge = 1'b0;
    stop_edge = 1'b0;
    adv = 2'b00;
    ovf = 2'b00;
    do_write = 1'b0;
    wr_ok = 1'b0;
    rd_val = 8'h00;
    rd_ok = 1'b0;
    st_next = st_reg;

    // free-running prescaler fed by the system clock
    st_next.psc = 7'(st_reg.psc + 7'h01);

    // event pin: two flops, then a third for edge detection
    st_next.ev_s1 = ctr1_event_i;
    st_next.ev_s2 = st_reg.ev_s1;
    st_next.ev_d = st_reg.ev_s2;
    rise = st_reg.ev_s2 & ~st_reg.ev_d;
    fall = ~st_reg.ev_s2 & st_reg.ev_d;

    // counter one advance condition per mode
    unique case (st_reg.ctr1_ctrl.mode)
      TECC_MODE_EVENT:
      begin
        // edge bit picks the counted edge; no prescaler here
        adv[`TECC_CTR1] = st_reg.ctr1_ctrl.run &
          (st_reg.ctr1_ctrl.edge_sel ? fall : rise); // R1
      end
      TECC_MODE_TIMER:
      begin
        adv[`TECC_CTR1] = st_reg.ctr1_ctrl.run & tick[`TECC_CTR1]; // R9
      end
      TECC_MODE_PULSE:
      begin
        // edge bit 0 measures the low phase; 1 measures the high one
        start_edge = st_reg.ctr1_ctrl.edge_sel ? rise : fall; // R2
        stop_edge = st_reg.ctr1_ctrl.edge_sel ? fall : rise; // R2
        if (!st_reg.ctr1_ctrl.run || stop_edge)
        begin
          st_next.pulse_active = 1'b0;
        end
        else if (start_edge)
        begin
          st_next.pulse_active = 1'b1;
        end
        adv[`TECC_CTR1] = st_reg.ctr1_ctrl.run & st_reg.pulse_active &
          ~stop_edge & tick[`TECC_CTR1]; // R2
      end
      TECC_MODE_PPG:
      begin
        // no mode for counter one at this code
        adv[`TECC_CTR1] = 1'b0;
      end
    endcase
    if (st_reg.ctr1_ctrl.mode != TECC_MODE_PULSE)
    begin
      st_next.pulse_active = 1'b0;
    end

    // counter two: timer or PPG timebase, other codes idle
    unique case (st_reg.ctr2_ctrl.mode)
      TECC_MODE_PPG, TECC_MODE_TIMER:
      begin
        adv[`TECC_CTR2] = st_reg.ctr2_ctrl.run & tick[`TECC_CTR2]; // R4 R7
      end
      TECC_MODE_EVENT, TECC_MODE_PULSE:
      begin
        adv[`TECC_CTR2] = 1'b0; // R5
      end
    endcase

    // count, reload on overflow; a stopped counter holds
    for (int i = 0; i < `TECC_NUM_CTR; i++)
    begin
      if (adv[i]) // R11
      begin
        if (st_reg.count[i] == `TECC_CNT_FULL)
        begin
          st_next.count[i] = st_reg.preload[i]; // R10
          ovf[i] = 1'b1; // R10
        end
        else
        begin
          st_next.count[i] = 8'(st_reg.count[i] + 8'h01); // R9
        end
      end
    end
    st_next.ovf_pulse = ovf;

    // ****************************************************************
    // axi write channel
    // ****************************************************************
    // address and data are caught in either order
    if (s_axi_awvalid_i && st_reg.awready)
    begin
      st_next.aw_held = 1'b1;
      st_next.waddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_reg.wready)
    begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata_i[7:0];
      st_next.wstrb0 = s_axi_wstrb_i[0];
    end
    if (st_reg.bvalid && s_axi_bready_i)
    begin
      st_next.bvalid = 1'b0;
    end

    // both halves held: commit and answer
    do_write = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
    st_next.sts = st_reg.sts | ovf; // R10
    if (do_write)
    begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      wr_ok = 1'b1;
      unique case (st_reg.waddr)
        `TECC_OFF_CTR1_CTRL:
        begin
          if (st_reg.wstrb0)
          begin
            st_next.ctr1_ctrl = st_reg.wdata;
          end
        end
        `TECC_OFF_CTR1_PRELOAD:
        begin
          if (st_reg.wstrb0)
          begin
            st_next.preload[`TECC_CTR1] = st_reg.wdata;
          end
        end
        `TECC_OFF_CTR2_CTRL:
        begin
          if (st_reg.wstrb0)
          begin
            // bits 5 and 3 are not stored
            st_next.ctr2_ctrl = st_reg.wdata &
              `TECC_CTR2_CTRL_WMASK; // R6
            // in PPG mode the run bit keeps its value
            if (st_reg.ctr2_ctrl.mode == TECC_MODE_PPG)
            begin
              st_next.ctr2_ctrl.run = st_reg.ctr2_ctrl.run; // R8
            end
          end
        end
        `TECC_OFF_CTR2_PRELOAD:
        begin
          if (st_reg.wstrb0)
          begin
            st_next.preload[`TECC_CTR2] = st_reg.wdata;
          end
        end
        `TECC_OFF_IRQ_STATUS:
        begin
          // write one to clear; a same-cycle overflow wins
          if (st_reg.wstrb0)
          begin
            st_next.sts = (st_reg.sts & ~st_reg.wdata[1:0]) | ovf;
          end
        end
        `TECC_OFF_IRQ_MASK:
        begin
          if (st_reg.wstrb0)
          begin
            st_next.msk = st_reg.wdata[1:0];
          end
        end
        `TECC_OFF_CTR1_COUNT, `TECC_OFF_CTR2_COUNT:
        begin
          // counts are read-only; the write is ignored
          wr_ok = 1'b1;
        end
        default:
        begin
          wr_ok = 1'b0;
        end
      endcase
      st_next.bresp = wr_ok ? `TECC_RESP_OKAY : `TECC_RESP_SLVERR;
    end
    // ready drops while a half waits, so one write at a time
    st_next.awready = ~st_next.aw_held & ~st_next.bvalid;
    st_next.wready = ~st_next.w_held & ~st_next.bvalid;

    // ****************************************************************
    // axi read channel
    // ****************************************************************
    if (st_reg.rvalid && s_axi_rready_i)
    begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st_reg.arready)
    begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr_i)
        `TECC_OFF_CTR1_CTRL: rd_val = st_reg.ctr1_ctrl;
        `TECC_OFF_CTR1_PRELOAD: rd_val = st_reg.preload[`TECC_CTR1];
        `TECC_OFF_CTR1_COUNT: rd_val = st_reg.count[`TECC_CTR1];
        `TECC_OFF_CTR2_CTRL:
        begin
          rd_val = st_reg.ctr2_ctrl & `TECC_CTR2_CTRL_WMASK; // R6
        end
        `TECC_OFF_CTR2_PRELOAD: rd_val = st_reg.preload[`TECC_CTR2];
        `TECC_OFF_CTR2_COUNT: rd_val = st_reg.count[`TECC_CTR2];
        `TECC_OFF_IRQ_STATUS: rd_val = {6'h00, st_reg.sts};
        `TECC_OFF_IRQ_MASK: rd_val = {6'h00, st_reg.msk};
        default:
        begin
          rd_ok = 1'b0;
        end
      endcase
      st_next.rvalid = 1'b1;
      st_next.rdata = {24'h00_0000, rd_val};
      st_next.rresp = rd_ok ? `TECC_RESP_OKAY : `TECC_RESP_SLVERR;
    end
    st_next.arready = ~st_next.rvalid;

    // level interrupt from masked sticky bits
    st_next.irq = |(st_next.sts & st_next.msk); // R10
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // synchronous reset; all outputs come from here
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
      st_reg.ctr1_ctrl <= `TECC_CTR1_CTRL_RST;
      st_reg.ctr2_ctrl <= `TECC_CTR2_CTRL_RST;
      st_reg.psc <= `TECC_PSC_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o = st_reg.wready;
  assign s_axi_bresp_o = st_reg.bresp;
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rdata_o = st_reg.rdata;
  assign s_axi_rresp_o = st_reg.rresp;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign irq_o = st_reg.irq;
  assign ctr1_overflow_o = st_reg.ovf_pulse[`TECC_CTR1];
  assign ctr2_overflow_o = st_reg.ovf_pulse[`TECC_CTR2];
  // timebase mode for the PPG module outside
  assign ctr2_operating_mode_o = tecc_mode_t'(st_reg.ctr2_ctrl.mode);

endmodule // tecc_timer_event_counter_ctrl

/* File: verification/tecc_ctrl_props.sv */
`timescale 1ns/1ps
// ****
// bus and interrupt checks
// ****
module tecc_ctrl_props
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic irq_o,
  input wire logic ctr1_overflow_o,
  input wire logic ctr2_overflow_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // registers are one byte wide, so the upper lanes never carry data
  a_rdata_upper: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:8] == 24'h00_0000) else $error("upper read bits set");
  a_err_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'b10
    |-> s_axi_rdata_o == 32'h0000_0000) else $error("error read not zero");
  a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  a_w_blocked: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o) else $error("write taken early");
  a_b_follows: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  a_r_follows: assert property (s_axi_arvalid_i && s_axi_arready_o
    |-> ##[1:2] s_axi_rvalid_o) else $error("read response late");
  a_ready_back: assert property (s_axi_bvalid_o && s_axi_bready_i
    |-> ##[1:3] s_axi_awready_o) else $error("write ready not restored");
  // an interrupt only rises on an overflow or a register write
  a_irq_cause: assert property ($rose(irq_o) |-> ctr1_overflow_o ||
    ctr2_overflow_o || s_axi_bvalid_o || $past(s_axi_bvalid_o))
    else $error("interrupt without cause");
  c_ovf2: cover property (ctr2_overflow_o);
  c_irq: cover property (irq_o);
  c_err: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'b10);
endmodule // tecc_ctrl_props

bind tecc_timer_event_counter_ctrl tecc_ctrl_props i_props
(
  .clk_sys_i(clk_sys_i),
  .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o),
  .irq_o(irq_o),
  .ctr1_overflow_o(ctr1_overflow_o),
  .ctr2_overflow_o(ctr2_overflow_o)
);

/* File: verification/tecc_event_src.sv */
`timescale 1ns/1ps
// ****
// external event pin model
// ****
module tecc_event_src
#(
  parameter int LOW_LEN = 10
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic pulse_req_i,
  output logic event_o
);
  logic [4:0] low_cnt_reg;
  // idle high; each request taken while idle gives one low pulse of fixed width
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      low_cnt_reg <= 5'h0;
    else if (pulse_req_i && low_cnt_reg == 5'h0)
      low_cnt_reg <= 5'(LOW_LEN);
    else if (low_cnt_reg != 5'h0)
      low_cnt_reg <= low_cnt_reg - 5'h1;
  end
  assign event_o = (low_cnt_reg == 5'h0);
endmodule // tecc_event_src

/* File: verification/test_timer_event_counter_ctrl.sv */
`timescale 1ns/1ps
// ****
// register level bench
// ****
module test_timer_event_counter_ctrl;
  import tecc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, pulse_req = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00, diff;
  logic [31:0] w_d = 32'h0000_0000;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, ev;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data, rd_val, cnt_a;
  tecc_mode_t mode2;
  logic ovf1, ovf2;
  int ovf1_cnt = 0, ovf2_cnt = 0, ovf_snap;
  int miscompares = 0;
  int total_checks = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  // overflow pulses counted from the outputs, sampled before the edge
  always @(posedge clk_sys_i)
  begin
    if (ovf1)
      ovf1_cnt <= ovf1_cnt + 1;
    if (ovf2)
      ovf2_cnt <= ovf2_cnt + 1;
  end

  // response ready held high: the master never stalls an answer
  tecc_timer_event_counter_ctrl i_dut
  (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ctr1_event_i(ev),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v),
    .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
    .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data),
    .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(1'b1),
    .irq_o(irq), .ctr1_overflow_o(ovf1), .ctr2_overflow_o(ovf2),
    .ctr2_operating_mode_o(mode2)
  );
  tecc_event_src i_src
  (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pulse_req_i(pulse_req),
    .event_o(ev)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    miscompares++;
    $display("CHECK FAILED at %0t: no answer", $time);
    print_verdict();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    aw_a <= a;
    w_d <= {24'h00_0000, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (aw_rdy)
        aw_v <= 1'b0;
      if (w_rdy)
        w_v <= 1'b0;
    end
    while (b_v !== 1'b1 && n < 50);
    if (n >= 50)
      hang();
    chk({30'h0, b_resp}, 32'h0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    int n;
    n = 0;
    ar_a <= a;
    ar_v <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (ar_rdy)
        ar_v <= 1'b0;
    end
    while (r_v !== 1'b1 && n < 50);
    if (n >= 50)
      hang();
    d = r_data;
    chk({30'h0, r_resp}, {30'h0, er});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, 2'b00, rd_val);
    chk(rd_val, exp);
  endtask

  task automatic pulses(input int k);
    repeat (k)
    begin
      pulse_req <= 1'b1;
      @(posedge clk_sys_i);
      pulse_req <= 1'b0;
      repeat (24) @(posedge clk_sys_i);
    end
  endtask

  // main sequence; every wait above is bounded
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rdc(8'h00, 32'h0000_0008);
    rdc(8'h0C, 32'h0000_0000);
    wr(8'h0C, 8'hFF);
    rdc(8'h0C, 32'h0000_00C7);
    wr(8'h0C, 8'hD0);
    repeat (20) @(posedge clk_sys_i);
    rdc(8'h14, 32'h0000_0000);
    wr(8'h0C, 8'h50);
    repeat (20) @(posedge clk_sys_i);
    rdc(8'h14, 32'h0000_0000);
    wr(8'h10, 8'hF0);
    wr(8'h1C, 8'h02);
    wr(8'h0C, 8'h98);
    rdc(8'h0C, 32'h0000_0090);
    chk({30'h0, mode2}, 32'h0000_0002);
    for (int n = 0; n < 400 && irq !== 1'b1; n++)
      @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(8'h0C, 8'h80);
    rd(8'h14, 2'b00, cnt_a);
    chk({31'h0, cnt_a[7:0] >= 8'hF0}, 32'h0000_0001);
    ovf_snap = ovf2_cnt;
    repeat (30) @(posedge clk_sys_i);
    rdc(8'h14, cnt_a);
    chk(ovf2_cnt, ovf_snap);
    rdc(8'h18, 32'h0000_0002);
    wr(8'h10, 8'h00);
    wr(8'h0C, 8'h93);
    repeat (400) @(posedge clk_sys_i);
    wr(8'h0C, 8'h83);
    rd(8'h14, 2'b00, rd_val);
    diff = rd_val[7:0] - cnt_a[7:0];
    chk({31'h0, diff >= 8'd49 && diff <= 8'd52}, 32'h0000_0001);
    // masking must drop the line while status stays set
    wr(8'h1C, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(8'h18, 8'h02);
    rdc(8'h18, 32'h0000_0000);
    wr(8'h0C, 8'h10);
    wr(8'h0C, 8'h00);
    rdc(8'h0C, 32'h0000_0010);
    wr(8'h00, 8'h50);
    pulses(3);
    rdc(8'h08, 32'h0000_0003);
    wr(8'h00, 8'h58);
    pulses(2);
    rdc(8'h08, 32'h0000_0005);
    wr(8'h00, 8'hD0);
    pulses(1);
    rd(8'h08, 2'b00, rd_val);
    chk({31'h0, rd_val >= 14 && rd_val <= 16}, 32'h0000_0001);
    // counter one as a timer: one wrap from the measured value
    chk(ovf1_cnt, 0);
    wr(8'h00, 8'h90);
    repeat (260) @(posedge clk_sys_i);
    chk(ovf1_cnt, 1);
    rd(8'h18, 2'b00, rd_val);
    chk({31'h0, rd_val[0]}, 32'h0000_0001);
    rd(8'h20, 2'b10, rd_val);
    chk(rd_val, 32'h0000_0000);
    print_verdict();
  end
endmodule // test_timer_event_counter_ctrl
